/* File: common/emc_defs.svh */
`ifndef EMC_DEFS_SVH
`define EMC_DEFS_SVH

// Register indices; byte address is four times the index
`define EMC_IDX_CLEAR 16'hf421
`define EMC_IDX_PMASK 16'hf422
`define EMC_IDX_SWMASK 16'hf423
`define EMC_IDX_WDMASK 16'hf424
`define EMC_IDX_STKMASK 16'hf425
`define EMC_IDX_LOOPMASK 16'hf426
`define EMC_IDX_FLAG 16'hf427
`define EMC_IDX_CODE 16'hf428

// Bus widths
`define EMC_ADDR_W 18
`define EMC_DATA_W 32
`define EMC_PAR_W 12
`define EMC_CODE_W 16

// Reset values
`define EMC_CLEAR_RST 1'h0
`define EMC_PMASK_RST 12'h003
`define EMC_SRCMASK_RST 1'h0

// Error source code bit positions
`define EMC_CODE_SW 15
`define EMC_CODE_LOOP 14
`define EMC_CODE_STACK 13
`define EMC_CODE_WD 12
`define EMC_CODE_DMB_LO 8
`define EMC_CODE_DMA_LO 4
`define EMC_CODE_PMB 3
`define EMC_CODE_PMA 2
`define EMC_CODE_RCB 1
`define EMC_CODE_RCA 0

`endif

/* File: common/emc_pkg.sv */
package emc_pkg;

	typedef enum logic [3:0]
	{
		EMC_REG_NONE = 4'h0,
		EMC_REG_CLEAR = 4'h1,
		EMC_REG_PMASK = 4'h2,
		EMC_REG_SWMASK = 4'h3,
		EMC_REG_WDMASK = 4'h4,
		EMC_REG_STKMASK = 4'h5,
		EMC_REG_LOOPMASK = 4'h6,
		EMC_REG_FLAG = 4'h7,
		EMC_REG_CODE = 4'h8
	} emc_reg_t;

	typedef logic [15:0] emc_code_t;
	typedef logic [11:0] emc_par_t;

endpackage

/* File: logic/emc_capture.sv */
`timescale 1ns/10ps
`include "emc_defs.svh"

module emc_capture
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic clr_pulse, // One-cycle clear request
	input wire emc_pkg::emc_code_t events, // Unmasked error events
	output emc_pkg::emc_code_t code, // Source of first error
	output logic flag // Sticky error flag
);
	import emc_pkg::*;

	logic flag_q;
	logic flag_d;
	emc_code_t code_q;
	emc_code_t code_d;

	always_comb
	begin
		flag_d = flag_q;
		code_d = code_q;
		if (clr_pulse)
		begin
			flag_d = 1'b0;
			code_d = '0;
		end
		// A new error in the clear cycle still wins and is captured
		if ((!flag_q || clr_pulse) && (|events))
		begin
			flag_d = 1'b1;
			code_d = events;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_q <= 1'b0;
			code_q <= '0;
		end
		else
		begin
			flag_q <= flag_d;
			code_q <= code_d;
		end
	end

	assign flag = flag_q;
	assign code = code_q;
endmodule

/* File: logic/emc_top.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`include "emc_defs.svh"

module emc_top
(
	input wire logic pclk, // System clock, 125 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction, high for write
	input wire logic [`EMC_ADDR_W-1:0] paddr, // APB byte address
	input wire logic [`EMC_DATA_W-1:0] pwdata, // APB write data
	output logic [`EMC_DATA_W-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire emc_pkg::emc_par_t parity_err, // Parity error pulses per memory
	input wire logic sw_err, // Software-raised error
	input wire logic wd_err, // Watchdog expiry error
	input wire logic stack_err, // Stack overrun error
	input wire logic loop_err, // Looping section error
	output logic error_flag, // Sticky error flag
	output emc_pkg::emc_code_t error_code // First error source
);
	import emc_pkg::*;

	function automatic emc_reg_t decode(input logic [`EMC_ADDR_W-1:0] addr);
		logic [15:0] idx;
		idx = addr[`EMC_ADDR_W-1:2];
		if (addr[1:0] != 2'h0)
			decode = EMC_REG_NONE;
		else
		begin
			case (idx)
				`EMC_IDX_CLEAR: decode = EMC_REG_CLEAR;
				`EMC_IDX_PMASK: decode = EMC_REG_PMASK;
				`EMC_IDX_SWMASK: decode = EMC_REG_SWMASK;
				`EMC_IDX_WDMASK: decode = EMC_REG_WDMASK;
				`EMC_IDX_STKMASK: decode = EMC_REG_STKMASK;
				`EMC_IDX_LOOPMASK: decode = EMC_REG_LOOPMASK;
				`EMC_IDX_FLAG: decode = EMC_REG_FLAG;
				`EMC_IDX_CODE: decode = EMC_REG_CODE;
				default: decode = EMC_REG_NONE;
			endcase
		end
	endfunction

	// Register state; only implemented bits are stored
	logic clear_q;
	logic clear_d;
	logic clear_prev_q;
	emc_par_t pmask_q;
	emc_par_t pmask_d;
	logic swmask_q;
	logic swmask_d;
	logic wdmask_q;
	logic wdmask_d;
	logic stkmask_q;
	logic stkmask_d;
	logic loopmask_q;
	logic loopmask_d;

	// Bus answer state
	logic [`EMC_DATA_W-1:0] prdata_q;
	logic [`EMC_DATA_W-1:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;

	emc_reg_t sel;
	logic setup;
	logic wr_en;
	logic clr_pulse;
	emc_code_t events;
	emc_code_t code_w;
	logic flag_w;

	assign sel = decode(paddr);
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

	always_comb
	begin
		clear_d = clear_q;
		pmask_d = pmask_q;
		swmask_d = swmask_q;
		wdmask_d = wdmask_q;
		stkmask_d = stkmask_q;
		loopmask_d = loopmask_q;
		if (wr_en)
		begin
			case (sel)
				EMC_REG_CLEAR: clear_d = pwdata[0];
				EMC_REG_PMASK: pmask_d = pwdata[`EMC_PAR_W-1:0];
				EMC_REG_SWMASK: swmask_d = pwdata[0];
				EMC_REG_WDMASK: wdmask_d = pwdata[0];
				EMC_REG_STKMASK: stkmask_d = pwdata[0];
				EMC_REG_LOOPMASK: loopmask_d = pwdata[0];
				default: clear_d = clear_q;
			endcase
		end
	end

	always_comb
	begin
		pready_d = setup;
		pslverr_d = setup && (sel == EMC_REG_NONE);
		prdata_d = prdata_q;
		if (setup)
		begin
			prdata_d = '0;
			case (sel)
				EMC_REG_CLEAR: prdata_d[0] = clear_q;
				EMC_REG_PMASK: prdata_d[`EMC_PAR_W-1:0] = pmask_q;
				EMC_REG_SWMASK: prdata_d[0] = swmask_q;
				EMC_REG_WDMASK: prdata_d[0] = wdmask_q;
				EMC_REG_STKMASK: prdata_d[0] = stkmask_q;
				EMC_REG_LOOPMASK: prdata_d[0] = loopmask_q;
				EMC_REG_FLAG: prdata_d[0] = flag_w;
				EMC_REG_CODE: prdata_d[`EMC_CODE_W-1:0] = code_w;
				default: prdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clear_q <= `EMC_CLEAR_RST;
			clear_prev_q <= `EMC_CLEAR_RST;
			pmask_q <= `EMC_PMASK_RST;
			swmask_q <= `EMC_SRCMASK_RST;
			wdmask_q <= `EMC_SRCMASK_RST;
			stkmask_q <= `EMC_SRCMASK_RST;
			loopmask_q <= `EMC_SRCMASK_RST;
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			clear_q <= clear_d;
			clear_prev_q <= clear_q;
			pmask_q <= pmask_d;
			swmask_q <= swmask_d;
			wdmask_q <= wdmask_d;
			stkmask_q <= stkmask_d;
			loopmask_q <= loopmask_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Only the 0 to 1 step of the clear bit acts
	assign clr_pulse = clear_q && !clear_prev_q;

	// Masks gate sources before capture, so latched state is untouched
	assign events[`EMC_CODE_SW] = sw_err && !swmask_q;
	assign events[`EMC_CODE_LOOP] = loop_err && !loopmask_q;
	assign events[`EMC_CODE_STACK] = stack_err && !stkmask_q;
	assign events[`EMC_CODE_WD] = wd_err && !wdmask_q;
	assign events[`EMC_PAR_W-1:0] = parity_err & ~pmask_q;

	emc_capture u_capture
	(
		.pclk(pclk),
		.presetn(presetn),
		.clr_pulse(clr_pulse),
		.events(events),
		.code(code_w),
		.flag(flag_w)
	);

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign error_flag = flag_w;
	assign error_code = code_w;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence seq_idle_quiet;
		!flag_w && !clr_pulse;
	endsequence

	sequence seq_clear_step;
		!clear_prev_q && clear_q;
	endsequence

	sequence seq_clear_write;
		wr_en && (sel == EMC_REG_CLEAR) && pwdata[0] && !clear_q;
	endsequence

	sequence seq_clear_fall;
		clear_prev_q && !clear_q;
	endsequence

	AST_CLEAR_EDGE: assert property ((seq_clear_step and (events == '0)) |=> !flag_w && (code_w == '0))
		else $error("clear edge did not reset the error flag");

	AST_CLEAR_HOLD: assert property ((flag_w && clear_q && clear_prev_q) |=> flag_w)
		else $error("holding clear high cleared the flag");

	AST_PAR_MASKED: assert property (
		(seq_idle_quiet and (parity_err != '0) && ((parity_err & ~pmask_q) == '0)
		&& !(sw_err && !swmask_q) && !(wd_err && !wdmask_q) && !(stack_err && !stkmask_q)
		&& !(loop_err && !loopmask_q)) |=> !flag_w)
		else $error("masked parity error was reported");

	AST_DMB_BANK: assert property ((seq_idle_quiet and parity_err[11] && !pmask_q[11]) |=> flag_w && code_w[11])
		else $error("data memory B bank 3 error lost");

	AST_DMA_BANK: assert property ((seq_idle_quiet and parity_err[4] && !pmask_q[4]) |=> flag_w && code_w[4])
		else $error("data memory A bank 0 error lost");

	AST_PM_A: assert property ((seq_idle_quiet and parity_err[2] && pmask_q[2]) |=> !code_w[2])
		else $error("masked program memory A error recorded");

	AST_SW_MASK: assert property ((seq_idle_quiet and sw_err && swmask_q) |=> !code_w[15])
		else $error("masked software error recorded");

	AST_WD_REPORT: assert property ((seq_idle_quiet and wd_err && !wdmask_q) |=> flag_w && code_w[12])
		else $error("watchdog error not reported");

	AST_STACK_REPORT: assert property ((seq_idle_quiet and stack_err && !stkmask_q) |=> code_w[13])
		else $error("stack error not reported");

	AST_LOOP_MASK: assert property ((seq_idle_quiet and loop_err && loopmask_q) |=> !code_w[14])
		else $error("masked loop error recorded");

	AST_STICKY: assert property ((flag_w && !clr_pulse) |=> flag_w)
		else $error("sticky flag dropped without clear");

	AST_FIRST_KEPT: assert property ((flag_w && !clr_pulse) |=> $stable(code_w))
		else $error("first error code changed before clear");

	AST_READ_RSVD: assert property ((setup && (sel == EMC_REG_SWMASK)) |=> prdata_q[31:1] == '0 && pready_q)
		else $error("reserved bits read nonzero");

	AST_DMB_BANK2: assert property ((seq_idle_quiet and parity_err[10] && !pmask_q[10]) |=> code_w[10])
		else $error("data memory B bank 2 error lost");

	AST_DMB_MASKED: assert property ((seq_idle_quiet and parity_err[8] && pmask_q[8]) |=> !code_w[8])
		else $error("masked data memory B bank 0 error recorded");

	AST_DMA_BANK3: assert property ((seq_idle_quiet and parity_err[7] && !pmask_q[7]) |=> code_w[7])
		else $error("data memory A bank 3 error lost");

	AST_DMA_MASKED: assert property ((seq_idle_quiet and parity_err[5] && pmask_q[5]) |=> !code_w[5])
		else $error("masked data memory A bank 1 error recorded");

	AST_PM_B: assert property ((seq_idle_quiet and parity_err[3] && !pmask_q[3]) |=> flag_w && code_w[3])
		else $error("program memory B error lost");

	AST_RC_MASKED: assert property ((seq_idle_quiet and (parity_err[1:0] != 2'h0) && (pmask_q[1:0] == 2'h3))
		|=> !code_w[1] && !code_w[0])
		else $error("masked rate converter error recorded");

	AST_RC_REPORT: assert property ((seq_idle_quiet and parity_err[0] && !pmask_q[0]) |=> flag_w && code_w[0])
		else $error("rate converter A error lost");

	AST_SW_REPORT: assert property ((seq_idle_quiet and sw_err && !swmask_q) |=> flag_w && code_w[15])
		else $error("software error not reported");

	AST_WD_MASK: assert property ((seq_idle_quiet and wd_err && wdmask_q) |=> !code_w[12])
		else $error("masked watchdog error recorded");

	AST_STACK_MASK: assert property ((seq_idle_quiet and stack_err && stkmask_q) |=> !code_w[13])
		else $error("masked stack error recorded");

	AST_LOOP_REPORT: assert property ((seq_idle_quiet and loop_err && !loopmask_q) |=> flag_w && code_w[14])
		else $error("loop error not reported");

	AST_FLAG_SET: assert property (((events != '0) && (!flag_w || clr_pulse)) |=> flag_w)
		else $error("unmasked error did not set the flag");

	AST_FLAG_RO: assert property ((wr_en && (sel == EMC_REG_FLAG) && flag_w && !clr_pulse) |=> flag_w)
		else $error("bus write changed the sticky flag");

	AST_FIRST_CODE: assert property ((!flag_w && (events != '0)) |=> code_w == $past(events))
		else $error("first error source not captured");

	AST_CODE_ZERO: assert property (!flag_w |-> code_w == '0)
		else $error("error code set without flag");

	AST_CLEAR_WRITE: assert property ((seq_clear_write ##1 (events == '0)) |=> !flag_w && (code_w == '0))
		else $error("clear write did not reset the manager");

	AST_CLEAR_FALL: assert property ((seq_clear_fall and flag_w) |=> flag_w)
		else $error("falling clear bit cleared the flag");

	AST_PMASK_WRITE: assert property ((wr_en && (sel == EMC_REG_PMASK)) |=> pmask_q == $past(pwdata[11:0]))
		else $error("parity mask write not stored");

	AST_MASK_KEEPS: assert property ((flag_w && !clr_pulse && wr_en && (sel != EMC_REG_CLEAR))
		|=> flag_w && $stable(code_w))
		else $error("register write altered latched error");
endmodule

/* File: tb/emc_top_tb_top.sv */
`timescale 1ns/10ps
`include "emc_defs.svh"

module emc_top_tb_top;
	import emc_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [`EMC_ADDR_W-1:0] paddr = '0;
	logic [`EMC_DATA_W-1:0] pwdata = '0;
	logic [`EMC_DATA_W-1:0] prdata;
	logic pready, pslverr, error_flag, last_err;
	logic sw_err = 1'b0, wd_err = 1'b0, stack_err = 1'b0, loop_err = 1'b0;
	emc_par_t parity_err = '0;
	emc_code_t error_code;
	logic [31:0] rdv;
	logic [1:0] boff = 2'b00;
	int errors = 0, check_count = 0, cyc = 0, i;

	always #4 pclk = ~pclk;

	emc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.parity_err(parity_err), .sw_err(sw_err), .wd_err(wd_err), .stack_err(stack_err),
		.loop_err(loop_err), .error_flag(error_flag), .error_code(error_code));

	task summarize;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			errors++;
			summarize();
		end
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			errors++;
		end
	endtask

	// One APB transfer; holds the request until pready is sampled high
	task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, boff};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk("pready wait", 32'h1, n);
		rdv = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle pulse on the sources, code bit order
	task drv(input logic [15:0] v);
		@(posedge pclk);
		{sw_err, loop_err, stack_err, wd_err, parity_err} <= v;
		@(posedge pclk);
		{sw_err, loop_err, stack_err, wd_err, parity_err} <= 16'h0000;
		@(posedge pclk);
		#1;
	endtask

	task expect_err(input logic [15:0] c);
		chk("error_flag", {31'h0, c != 16'h0000}, {31'h0, error_flag});
		chk("error_code", {16'h0, c}, {16'h0, error_code});
	endtask

	task clr;
		apb(1'b1, `EMC_IDX_CLEAR, 32'h1);
		apb(1'b1, `EMC_IDX_CLEAR, 32'h0);
		repeat (3) @(posedge pclk);
		#1;
	endtask

	task t_reset;
		for (i = 0; i < 8; i++)
		begin
			apb(1'b0, `EMC_IDX_CLEAR + 16'(i), 32'h0);
			chk("reset value", (i == 1) ? 32'h3 : 32'h0, rdv);
		end
		drv(16'h0003);
		expect_err(16'h0000);
	endtask

	task t_sources;
		apb(1'b1, `EMC_IDX_PMASK, 32'h0);
		for (i = 0; i < 16; i++)
		begin
			drv(16'h1 << i);
			expect_err(16'h1 << i);
			apb(1'b0, `EMC_IDX_CODE, 32'h0);
			chk("code register", 32'h1 << i, rdv);
			clr();
			expect_err(16'h0000);
		end
	endtask

	task t_masks;
		for (i = 1; i < 6; i++)
		begin
			apb(1'b1, `EMC_IDX_CLEAR + 16'(i), 32'hffffffff);
			apb(1'b0, `EMC_IDX_CLEAR + 16'(i), 32'h0);
			chk("mask readback", (i == 1) ? 32'hfff : 32'h1, rdv);
		end
		drv(16'hffff);
		expect_err(16'h0000);
		apb(1'b1, `EMC_IDX_SWMASK, 32'h0);
		drv(16'hffff);
		expect_err(16'h8000);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `EMC_IDX_PMASK, 32'h0);
		chk("pmask after reset", 32'h3, rdv);
		apb(1'b0, `EMC_IDX_SWMASK, 32'h0);
		chk("sw mask after reset", 32'h0, rdv);
		expect_err(16'h0000);
		clr();
	endtask

	task t_order;
		for (i = 1; i < 6; i++)
			apb(1'b1, `EMC_IDX_CLEAR + 16'(i), 32'h0);
		drv(16'h1000);
		drv(16'h8000);
		expect_err(16'h1000);
		apb(1'b1, `EMC_IDX_WDMASK, 32'h1);
		expect_err(16'h1000);
		apb(1'b1, `EMC_IDX_CLEAR, 32'h1);
		repeat (3) @(posedge pclk);
		#1;
		expect_err(16'h0000);
		drv(16'h0010);
		apb(1'b1, `EMC_IDX_CLEAR, 32'h1);
		repeat (3) @(posedge pclk);
		#1;
		expect_err(16'h0010);
		apb(1'b1, `EMC_IDX_CLEAR, 32'h0);
		repeat (3) @(posedge pclk);
		#1;
		expect_err(16'h0010);
		clr();
		expect_err(16'h0000);
	endtask

	task t_bus;
		apb(1'b0, 16'hf430, 32'h0);
		chk("unmapped pslverr", 32'h1, {31'h0, last_err});
		chk("unmapped data", 32'h0, rdv);
		boff = 2'b10;
		apb(1'b1, `EMC_IDX_SWMASK, 32'h1);
		boff = 2'b00;
		chk("misaligned pslverr", 32'h1, {31'h0, last_err});
		apb(1'b0, `EMC_IDX_SWMASK, 32'h0);
		chk("misaligned write ignored", 32'h0, rdv);
		drv(16'h0004);
		apb(1'b1, `EMC_IDX_FLAG, 32'h0);
		apb(1'b0, `EMC_IDX_FLAG, 32'h0);
		chk("flag register", 32'h1, rdv);
		apb(1'b1, `EMC_IDX_CODE, 32'h0);
		apb(1'b0, `EMC_IDX_CODE, 32'h0);
		chk("code register", 32'h4, rdv);
		chk("mapped pslverr", 32'h0, {31'h0, last_err});
	endtask

	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_sources();
		t_masks();
		t_order();
		t_bus();
		summarize();
	end
endmodule
